// >>> tb/tps_link_model.sv
// link partner: slave timing source and remote slot traffic
`timescale 1ns/1ps
`default_nettype none
module tps_link_model import tps_pkg::*; #(
   parameter logic [7:0] PAT = 8'h96
) (
   // control from the bench
   input  wire logic       run,
   input  wire logic       speech,
   input  wire logic [5:0] nslots,
   input  wire logic [4:0] watch,
   // line side; data line has a pull-up
   input  wire logic       serial_out_oe,
   output tps_pins_in_t    pins_in,
   output logic [7:0]      seen,
   output int              frames
);
   logic [7:0] cap;
   logic [7:0] sb;
   initial begin
      pins_in = '0;
      seen = 8'hFF;
      cap = 8'hFF;
      frames = 0;
   end
   // one frame a pass; clock stands low while idle
   always begin
      wait (run);
      for (int s = 0; s < nslots; s++) begin
         sb = PAT ^ 8'(s);
         for (int b = 0; b < 8; b++) begin
            for (int h = 0; h < (speech ? 1 : 2); h++) begin
               pins_in.frame_sync = (s == 0 && b == 0 && h == 0);
               pins_in.serial_in = sb[7-b];
               #200;
               pins_in.bit_clock = 1'b1;
               #200;
               // sample late in the bit, just before the closing fall
               if (s == watch && h == (speech ? 0 : 1))
                  cap[7-b] = !serial_out_oe;
               pins_in.bit_clock = 1'b0;
            end
         end
      end
      seen = cap;
      frames++;
      #1;
   end
endmodule
`default_nettype wire

// >>> tb/tps_serial_port_tb.sv
// bench: register access, slot traffic per mode, disabled and master
`timescale 1ns/1ps
`default_nettype none
module tps_serial_port_tb import tps_pkg::*;;
   logic          mclk = 1'b0;
   logic          nrst = 1'b0;
   logic [1:0]    reg_addr = 2'h0;
   logic [15:0]   reg_wdata = 16'h0000;
   logic          reg_wr = 1'b0;
   logic          reg_rd = 1'b0;
   logic [15:0]   reg_rdata;
   logic          rx_word_ready;
   tps_pins_in_t  pins_in;
   tps_pins_out_t pins_out;
   logic          run = 1'b0;
   logic          speech = 1'b0;
   logic [5:0]    nslots = 6'h04;
   logic [4:0]    watch = 5'h00;
   logic [7:0]    seen;
   int            frames;
   int            error_cnt = 0;
   int            checks = 0;
   int            rdy_n = 0;
   int            r0;
   localparam logic [2:0] MC [6] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h7, 3'h6};
   localparam int         MS [6] = '{4, 8, 12, 16, 32, 32};
   always #25 mclk = ~mclk;
   // count ready pulses where they are settled, away from the launch edge
   always @(negedge mclk) if (rx_word_ready === 1'b1) rdy_n++;
   tps_serial_port tps_serial_port_i (.mclk(mclk), .nrst(nrst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pins_in(pins_in),
      .pins_out(pins_out), .rx_word_ready(rx_word_ready));
   tps_link_model tps_link_model_i (.run(run), .speech(speech),
      .nslots(nslots), .watch(watch), .serial_out_oe(pins_out.serial_out_oe),
      .pins_in(pins_in), .seen(seen), .frames(frames));
   task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(logic [1:0] a, logic [15:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rchk(string nm, logic [1:0] a, logic [15:0] exp);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(negedge mclk);
      chk(nm, reg_rdata, exp);
   endtask
   // stop the partner at a frame boundary so config never changes mid-frame
   task automatic frames_wait(int n);
      int f0;
      f0 = frames;
      wait (frames == f0 + n);
      run = 1'b0;
      // let the last slot land through the pin synchronisers
      repeat (6) @(posedge mclk);
   endtask
   task results;
      $display("mismatches %0d of %0d checks", error_cnt, checks);
      if (error_cnt == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #4_000_000;
      error_cnt++;
      results;
   end
   initial begin
      repeat (12) @(posedge mclk);
      nrst <= 1'b1;
      rchk("rx reset", ADDR_RX_WORD, RESET_WORD);
      rchk("tx reset", ADDR_TX_WORD, RESET_WORD);
      rchk("ctl reset", ADDR_CONTROL, RESET_WORD);
      rchk("alt reset", ADDR_ALT_SEL, 16'h0000);
      chk("pins reset", 16'(pins_out), 16'h0000);
      wr(ADDR_RX_WORD, 16'h1234);
      rchk("rx read only", ADDR_RX_WORD, RESET_WORD);
      wr(ADDR_TX_WORD, 16'hC35A);
      wr(ADDR_ALT_SEL, 16'h0040);
      rchk("alt readback", ADDR_ALT_SEL, 16'h0040);
      // every active code; channel 0 in the last slot, channel 1 in slot 1
      for (int m = 0; m < 6; m++) begin
         nslots = 6'(MS[m]);
         watch = 5'(MS[m] - 1);
         speech = (MC[m] == MODE_SPEECH);
         wr(ADDR_CONTROL, {MC[m], watch, 3'h3, 5'h01});
         rchk("ctl", ADDR_CONTROL, {MC[m], watch, 3'h3, 5'h01});
         r0 = rdy_n;
         run = 1'b1;
         frames_wait(2);
         chk("ready pulses", 16'(rdy_n - r0), 16'h0004);
         rchk("rx word", ADDR_RX_WORD, {8'h97, 8'h96 ^ 8'(watch)});
         chk("tx slot", {8'h00, seen}, 16'h005A);
      end
      // inactive codes: line released, rx word holds
      for (int c = 0; c < 2; c++) begin
         nslots = 6'h04;
         watch = 5'h02;
         speech = 1'b0;
         wr(ADDR_CONTROL, {3'(c), 5'h02, 3'h3, 5'h01});
         r0 = rdy_n;
         run = 1'b1;
         frames_wait(2);
         chk("off ready", 16'(rdy_n - r0), 16'h0000);
         chk("off line", {8'h00, seen}, 16'h00FF);
         rchk("off rx", ADDR_RX_WORD, 16'h9789);
      end
      wr(ADDR_ALT_SEL, 16'h0060);
      wr(ADDR_CONTROL, {MODE_MS12, 13'h0000});
      repeat (4) @(posedge mclk);
      chk("master oe", 16'({pins_out.frame_sync_oe, pins_out.bit_clock_oe}),
          16'h0003);
      repeat (6000) @(posedge mclk);
      wr(ADDR_CONTROL, {MODE_S32, 13'h0000});
      repeat (4) @(posedge mclk);
      chk("slave oe", 16'({pins_out.frame_sync_oe, pins_out.bit_clock_oe}),
          16'h0000);
      results;
   end
endmodule
`default_nettype wire

// >>> tb/tps_sva.sv
// checker: port-level properties of the serial port
`timescale 1ns/1ps
`default_nettype none
module tps_sva import tps_pkg::*; #(
   parameter int ADDR_W = 2
) (
   // clock and reset
   input wire logic              mclk,
   input wire logic              nrst,
   // register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [15:0]       reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [15:0]       reg_rdata,
   // pins and status
   input wire tps_pins_in_t      pins_in,
   input wire tps_pins_out_t     pins_out,
   input wire logic              rx_word_ready
);
   logic [15:0] ctl_q;
   logic [15:0] tx_q;
   logic [7:0]  alt_q;
   // shadow of software writes, so reads can be predicted
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ctl_q <= 16'h0000;
         tx_q  <= 16'h0000;
         alt_q <= 8'h00;
      end else if (reg_wr) begin
         if (reg_addr == ADDR_CONTROL) ctl_q <= reg_wdata;
         if (reg_addr == ADDR_TX_WORD) tx_q <= reg_wdata;
         if (reg_addr == ADDR_ALT_SEL) alt_q <= reg_wdata[7:0];
      end
   end
   wire off   = ctl_q[15:14] == 2'h0;
   wire noact = !ctl_q[6] && !ctl_q[5];
   wire mst   = alt_q[6] && alt_q[5] && ctl_q[15:13] == 3'h4;
   wire oe    = pins_out.serial_out_oe;
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   property p_rd_idle; !reg_rd |=> reg_rdata == 16'h0000; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
   property p_rd_ctl;
      reg_rd && reg_addr == ADDR_CONTROL |=> reg_rdata == ctl_q;
   endproperty
   a_rd_ctl: assert property (p_rd_ctl) else $error("control read");
   property p_rd_tx;
      reg_rd && reg_addr == ADDR_TX_WORD |=> reg_rdata == tx_q;
   endproperty
   a_rd_tx: assert property (p_rd_tx) else $error("tx word read");
   property p_off; off [*4] |-> !oe && !rx_word_ready; endproperty
   a_off: assert property (p_off) else $error("active while off");
   property p_alt; !alt_q[6] [*4] |-> !oe; endproperty
   a_alt: assert property (p_alt) else $error("drives, pins off");
   property p_noact; noact [*4] |-> !oe && !rx_word_ready; endproperty
   a_noact: assert property (p_noact) else $error("idle channel");
   property p_slave;
      !mst [*3] |-> !pins_out.frame_sync_oe && !pins_out.bit_clock_oe;
   endproperty
   a_slave: assert property (p_slave) else $error("slave drives");
   property p_master;
      mst [*3] |-> pins_out.frame_sync_oe && pins_out.bit_clock_oe;
   endproperty
   a_master: assert property (p_master) else $error("master idle");
   property p_mclk;
      mst && $rose(pins_out.bit_clock_o)
         |-> ##[5:8] ($fell(pins_out.bit_clock_o) || !mst);
   endproperty
   a_mclk: assert property (p_mclk) else $error("bit clock rate");
   property p_pulse; rx_word_ready |=> !rx_word_ready; endproperty
   a_pulse: assert property (p_pulse) else $error("ready too long");
   c_rx: cover property (rx_word_ready);
   c_oe: cover property (oe);
   c_mst: cover property (mst && $rose(pins_out.bit_clock_o));
endmodule
bind tps_serial_port tps_sva #(.ADDR_W(ADDR_W)) tps_sva_i (.mclk(mclk),
   .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pins_in(pins_in),
   .pins_out(pins_out), .rx_word_ready(rx_word_ready));
`default_nettype wire

// >>> verilog/tps_pkg.sv
// package: register map, field layout, mode codes and timing for the serial port
package tps_pkg;
   // register word indices on the plain register port
   localparam logic [1:0] ADDR_RX_WORD  = 2'h0;
   localparam logic [1:0] ADDR_TX_WORD  = 2'h1;
   localparam logic [1:0] ADDR_CONTROL  = 2'h2;
   localparam logic [1:0] ADDR_ALT_SEL  = 2'h3;
   localparam logic [15:0] RESET_WORD   = 16'h0000;
   localparam logic [7:0]  RESET_ALT    = 8'h00;
   // port_control field positions
   localparam int CTL_MODE_HI = 15;
   localparam int CTL_MODE_LO = 13;
   localparam int CTL_SLOT0_HI = 12;
   localparam int CTL_SLOT0_LO = 8;
   localparam int CTL_ACT0    = 6;
   localparam int CTL_ACT1    = 5;
   localparam int CTL_SLOT1_HI = 4;
   localparam int CTL_SLOT1_LO = 0;
   // alt_function_select field positions
   localparam int ALT_PINS_EN = 6;
   localparam int ALT_MASTER  = 5;
   // mode codes
   typedef enum logic [2:0] {
      MODE_OFF0   = 3'h0,
      MODE_OFF1   = 3'h1,
      MODE_S4     = 3'h2,
      MODE_S8     = 3'h3,
      MODE_MS12   = 3'h4,
      MODE_S16    = 3'h5,
      MODE_SPEECH = 3'h6,
      MODE_S32    = 3'h7
   } tps_mode_t;
   localparam int SLOT_BITS = 8;
   // master timing: 8 kHz frame, 12 slots of 8 bits, two clock periods a bit
   localparam int FRAME_HZ      = 8000;
   localparam int MASTER_SLOTS  = 12;
   localparam int MCLK_HZ       = 20000000;
   localparam int MASTER_HALF_PER_FRAME = MASTER_SLOTS * SLOT_BITS * 2 * 2;
   localparam int MASTER_FRAME_CYC = MCLK_HZ / FRAME_HZ;
   // pins seen from the block
   typedef struct packed {
      logic serial_in;
      logic frame_sync;
      logic bit_clock;
   } tps_pins_in_t;
   typedef struct packed {
      logic serial_out_oe;
      logic frame_sync_o;
      logic frame_sync_oe;
      logic bit_clock_o;
      logic bit_clock_oe;
   } tps_pins_out_t;
endpackage

// >>> verilog/tps_serial_port.sv
// serial port top: registers, pin synchronisers, slot counter, shifters
//
// What this block does
// R01: codes 000/001 disable port; reset default
// R02: code 010 slave, four slots
// R03: code 011 slave, eight slots
// R04: code 100 twelve slots, master or slave
// R05: code 101 slave, sixteen slots
// R06: code 111 slave, 32 slots, doubled clock
// R07: code 110 speech mode, undoubled clock
// R08: other modes: two clocks per bit
// R09: speech mode: one clock per bit
// R10: reset leaves sync and clock inputs
// R11: master drives sync and clock push-pull
// R12: software pairs master with code 100
// R13: alt select bit6 pins, bit5 master
// R14: frame sync rise starts slot zero
// R15: eight bits per slot, mode count
// R16: data out open drain, own slots
// R17: capture eight or sixteen bit units
// R18: tx word shifted out in slot
// R19: two channels, linear uses two slots; code gives each channel one slot
// R20: high byte channel 1, low channel 0
// R21: control field layout as mapped
// R22: slot value counts from frame sync
// R23: msb first, change/sample opposite edges
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module tps_serial_port import tps_pkg::*; #(
   parameter int ADDR_W = 2
) (
   // clock and reset
   input  wire logic          mclk,
   input  wire logic          nrst,
   // register port
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [15:0]   reg_wdata,
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   output logic [15:0]        reg_rdata,
   // link pins
   input  wire tps_pins_in_t  pins_in,
   output tps_pins_out_t      pins_out,
   // status for the dsp side
   output logic               rx_word_ready
);
   // four registers need at least two address bits
   if (ADDR_W < 2) begin : g_addr_chk
      $error("ADDR_W must be at least 2");
   end

   // registers
   logic [15:0] rx_word_q, tx_word_q, ctl_q, ctl_d;
   logic [7:0]  alt_q;
   logic [15:0] rdata_d;
   tps_pins_out_t pins_q, pins_d;
   logic        ready_q;

   // decode
   wire sel_rx  = reg_addr == ADDR_W'(ADDR_RX_WORD);
   wire sel_tx  = reg_addr == ADDR_W'(ADDR_TX_WORD);
   wire sel_ctl = reg_addr == ADDR_W'(ADDR_CONTROL);
   wire sel_alt = reg_addr == ADDR_W'(ADDR_ALT_SEL);

   // control fields, laid out as mapped; bit 7 spare
   wire [2:0] mode_raw  = ctl_q[CTL_MODE_HI:CTL_MODE_LO];     // see R21
   wire [4:0] slot0_pos = ctl_q[CTL_SLOT0_HI:CTL_SLOT0_LO];   // see R21
   wire [4:0] slot1_pos = ctl_q[CTL_SLOT1_HI:CTL_SLOT1_LO];   // see R21
   wire       act0      = ctl_q[CTL_ACT0];
   wire       act1      = ctl_q[CTL_ACT1];
   tps_mode_t mode;
   assign mode = tps_mode_t'(mode_raw);

   // alternate function bits
   wire pins_en   = alt_q[ALT_PINS_EN];                       // see R13
   wire master_req = alt_q[ALT_MASTER];                       // see R13
   wire port_on   = pins_en && (mode != MODE_OFF0)
                    && (mode != MODE_OFF1);                   // see R01
   // master only honoured with the twelve-slot code; others stay slave
   wire is_master = port_on && master_req && (mode == MODE_MS12); // see R04 R12
   wire speech    = (mode == MODE_SPEECH);

   // slots per frame for the selected code, minus one
   function automatic logic [4:0] last_slot(input tps_mode_t m);
      case (m)
         MODE_S4:     last_slot = 5'h03;                      // see R02
         MODE_S8:     last_slot = 5'h07;                      // see R03
         MODE_MS12:   last_slot = 5'h0B;                      // see R04
         MODE_S16:    last_slot = 5'h0F;                      // see R05
         MODE_SPEECH: last_slot = 5'h1F;                      // see R07
         MODE_S32:    last_slot = 5'h1F;                      // see R06
         default:     last_slot = 5'h00;
      endcase
   endfunction

   // register writes; the rx word is only written by the link side
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         tx_word_q <= RESET_WORD;
         ctl_q     <= RESET_WORD;                             // see R01
         alt_q     <= RESET_ALT;                              // see R10
      end else begin
         if (reg_wr && sel_tx)  tx_word_q <= reg_wdata;
         ctl_q <= ctl_d;
         if (reg_wr && sel_alt) alt_q <= reg_wdata[7:0];
      end
   end
   assign ctl_d = (reg_wr && sel_ctl) ? reg_wdata : ctl_q;

   // read mux; unmapped addresses read zero
   assign rdata_d = !reg_rd ? 16'h0000 :
                    sel_rx  ? rx_word_q :
                    sel_tx  ? tx_word_q :
                    sel_ctl ? ctl_q :
                    sel_alt ? {8'h00, alt_q} : 16'h0000;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) reg_rdata <= 16'h0000;
      else       reg_rdata <= rdata_d;
   end

   // master timing generator
   logic gen_clk, gen_fs;
   tps_timing_gen u_gen (
      .mclk         (mclk),
      .nrst         (nrst),
      .run          (is_master),
      .bit_clock_o  (gen_clk),
      .frame_sync_o (gen_fs)
   );

   // two-flop synchronisers on pins; first stage read by second only
   logic [2:0] sync1_q, sync2_q;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
      end else begin
         sync1_q <= {pins_in.serial_in, pins_in.frame_sync, pins_in.bit_clock};
         sync2_q <= sync1_q;
      end
   end
   wire din_s = sync2_q[2];
   // in master mode count our own generated timing
   wire fs_s  = is_master ? gen_fs  : sync2_q[1];             // see R11
   wire dck_s = is_master ? gen_clk : sync2_q[0];

   // edge detection
   logic dck_prev_q, fs_prev_q;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         dck_prev_q <= 1'b0;
         fs_prev_q  <= 1'b0;
      end else begin
         dck_prev_q <= dck_s;
         fs_prev_q  <= fs_s;
      end
   end
   wire dck_rise = dck_s && !dck_prev_q;
   wire dck_fall = !dck_s && dck_prev_q;
   wire fs_rise  = fs_s && !fs_prev_q;

   // bit timing: doubled clock uses a phase bit, speech one per period
   logic       phase_q;
   logic [2:0] bit_q;
   logic [4:0] slot_q;
   logic       framed_q;
   wire bit_end  = dck_fall && (speech || phase_q);           // see R08 R09
   wire slot_end = bit_end && (bit_q == 3'(SLOT_BITS - 1));   // see R15
   wire frame_end = slot_end && (slot_q == last_slot(mode));
   // sample on the rising edge inside the second half of the bit
   wire sample  = dck_rise && (speech || phase_q);            // see R23

   // frame, slot and bit counters aligned to frame sync
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         phase_q  <= 1'b0;
         bit_q    <= 3'h0;
         slot_q   <= 5'h00;
         framed_q <= 1'b0;
      end else if (!port_on) begin                            // see R01
         phase_q  <= 1'b0;
         bit_q    <= 3'h0;
         slot_q   <= 5'h00;
         framed_q <= 1'b0;
      end else if (fs_rise) begin                             // see R14
         phase_q  <= 1'b0;
         bit_q    <= 3'h0;
         slot_q   <= 5'h00;
         framed_q <= 1'b1;
      end else begin
         if (dck_fall) phase_q <= speech ? 1'b0 : ~phase_q;
         if (bit_end)  bit_q <= bit_q + 3'h1;
         if (frame_end) begin
            slot_q   <= 5'h00;
            framed_q <= 1'b0;                                 // wait next sync
         end else if (slot_end) begin
            slot_q <= slot_q + 5'h01;
         end
      end
   end

   // channel slot match; each channel takes only the slot at its pos (one
   // byte per channel; when both point at one slot both lanes take that byte)
   wire in_ch0 = framed_q && act0 && (slot_q == slot0_pos);   // see R22
   wire in_ch1 = framed_q && act1 && (slot_q == slot1_pos);   // see R22 R19

   // receive shifters per channel, msb first
   logic [7:0] rx0_sh_q, rx1_sh_q;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rx0_sh_q  <= 8'h00;
         rx1_sh_q  <= 8'h00;
         rx_word_q <= RESET_WORD;
         ready_q   <= 1'b0;
      end else begin
         ready_q <= 1'b0;
         if (sample && in_ch0) rx0_sh_q <= {rx0_sh_q[6:0], din_s}; // see R23
         if (sample && in_ch1) rx1_sh_q <= {rx1_sh_q[6:0], din_s};
         // a full byte lands in its lane at slot end
         if (slot_end && in_ch0) begin
            rx_word_q[7:0] <= rx0_sh_q;                       // see R17 R20
            ready_q <= 1'b1;
         end
         if (slot_end && in_ch1) begin
            rx_word_q[15:8] <= rx1_sh_q;                      // see R17 R20
            ready_q <= 1'b1;
         end
      end
   end
   assign rx_word_ready = ready_q;

   // transmit: pick the bit of the channel owning the slot, msb first
   wire [2:0] tx_idx = 3'(SLOT_BITS - 1) - bit_q;
   wire tx_bit = in_ch0 ? tx_word_q[tx_idx] :                 // see R18 R20
                 tx_word_q[4'(8) + {1'b0, tx_idx}];
   wire tx_own = in_ch0 || in_ch1;

   // pin drive: open drain data pulls low only for a zero in own slots
   always_comb begin
      pins_d = '0;
      pins_d.serial_out_oe = port_on && tx_own && !tx_bit;    // see R16
      pins_d.frame_sync_o  = gen_fs;
      pins_d.bit_clock_o   = gen_clk;
      pins_d.frame_sync_oe = is_master;                       // see R11 R10
      pins_d.bit_clock_oe  = is_master;
   end
   // one cycle after the fall the counters already name the new bit;
   // loading on the fall itself would show the previous bit a bit late
   logic fall_dly_q;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) fall_dly_q <= 1'b0;
      else       fall_dly_q <= dck_fall;
   end
   // in own slots data only changes once the data clock has fallen: change on fall; master pins load every cycle
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) pins_q <= '0;
      else if (fall_dly_q || !tx_own || !port_on
               || is_master != pins_q.bit_clock_oe
               || is_master)
         pins_q <= pins_d;                                    // see R23
   end
   assign pins_out = pins_q;
endmodule
`default_nettype wire

// >>> verilog/tps_timing_gen.sv
// timing generator: master frame sync and bit clock from mclk
`timescale 1ns/1ps
`default_nettype none
module tps_timing_gen import tps_pkg::*; (
   // clock and reset
   input  wire logic mclk,
   input  wire logic nrst,
   // control
   input  wire logic run,
   // generated link signals
   output logic      bit_clock_o,
   output logic      frame_sync_o
);
   localparam int CNT_W = $clog2(MASTER_FRAME_CYC);
   localparam logic [CNT_W-1:0] FRAME_LAST = CNT_W'(MASTER_FRAME_CYC - 1);
   // 2500 cycles per frame do not divide into 384 half periods, so the
   // half period is a fractional accumulator: jitter of one mclk period
   localparam logic [CNT_W+9:0] HALF_STEP = (CNT_W+10)'(MASTER_HALF_PER_FRAME);
   localparam logic [CNT_W+9:0] HALF_WRAP = (CNT_W+10)'(MASTER_FRAME_CYC);

   logic [CNT_W-1:0]  frame_cnt_q;
   logic [CNT_W+9:0]  acc_q;
   logic [CNT_W+9:0]  acc_sum;
   logic              toggle;

   assign acc_sum = acc_q + HALF_STEP;
   assign toggle  = acc_sum >= HALF_WRAP;

   // free-running frame divider while the port is master
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         frame_cnt_q  <= '0;
         acc_q        <= '0;
         bit_clock_o  <= 1'b0;
         frame_sync_o <= 1'b0;
      end else if (!run) begin
         frame_cnt_q  <= '0;
         acc_q        <= '0;
         bit_clock_o  <= 1'b0;
         frame_sync_o <= 1'b0;
      end else begin
         frame_cnt_q  <= (frame_cnt_q == FRAME_LAST) ? '0 : frame_cnt_q + 1'b1;
         acc_q        <= toggle ? acc_sum - HALF_WRAP : acc_sum;
         bit_clock_o  <= (frame_cnt_q == FRAME_LAST) ? 1'b0 :
                         (toggle ? ~bit_clock_o : bit_clock_o);
         // high for the first bit clock period of each frame
         frame_sync_o <= (frame_cnt_q < CNT_W'(MASTER_FRAME_CYC / 192));
      end
   end
endmodule
`default_nettype wire
